// >>> adc_fmt_defines.svh
// Notes on behaviour
// (RQ1) Right justified, the high data byte holds result bits 11..8 low, upper nibble copies its bit 3 for differential only.
// (RQ2) Left justified, the high data byte holds the eight most significant result bits.
// (RQ3) Right justified, the low data byte holds the eight least significant result bits.
// (RQ4) Left justified, low byte bits 7..4 hold result bits 3..0 and bits 3..0 always read zero.
// (RQ5) Right justified, the upper nibble is zero for single-ended and sign extension for differential.
// (RQ6) Single-ended codes are unsigned 12-bit, differential codes are two's complement.
// (RQ7) Every new result is compared with the limits by hardware and sets the window flag on a hit.
// (RQ8) Both limits are 16-bit words split into separately writable high and low byte registers.
// (RQ9) Whether inside or outside the window is flagged depends only on how the two limits relate.
// (RQ10) The window flag can be polled and also drives an interrupt request line.
// (RQ11) The window flag is sticky and only a software write of zero clears it.
// (RQ12) Justify select bit 0 picks right justification when zero and left when one.
// (RQ13) If the lower limit exceeds the upper, results strictly between flag; else below lower or above upper.
`ifndef ADC_FMT_DEFINES_SVH
`define ADC_FMT_DEFINES_SVH

`define ADDR_RESULT_LOW        8'hbe
`define ADDR_RESULT_HIGH       8'hbf
`define ADDR_UPPER_LIMIT_LOW   8'hc4
`define ADDR_UPPER_LIMIT_HIGH  8'hc5
`define ADDR_LOWER_LIMIT_LOW   8'hc6
`define ADDR_LOWER_LIMIT_HIGH  8'hc7
`define ADDR_CONTROL           8'he8

`define CTRL_JUSTIFY_BIT       0
`define CTRL_WINDOW_FLAG_BIT   1

`define RESET_RESULT           8'h00
`define RESET_CONTROL          8'h00
`define RESET_UPPER_LIMIT      8'hff
`define RESET_LOWER_LIMIT      8'h00
`define READ_UNMAPPED          8'h00

`endif

// >>> adc_fmt_pkg.sv
package adc_fmt_pkg;
    typedef enum logic {
        JUSTIFY_RIGHT = 1'b0,
        JUSTIFY_LEFT  = 1'b1
    } justify_t;
    typedef logic [7:0]  byte_t;
    typedef logic [11:0] code_t;
    typedef logic [15:0] data_word_t;
endpackage

// >>> adc_window_compare.sv
`timescale 1ns/1ns
`default_nettype none
module adc_window_compare
    import adc_fmt_pkg::*;
(
    input  wire data_word_t word_in,
    input  wire data_word_t upper_in,
    input  wire data_word_t lower_in,
    input  wire logic       signed_in,
    output logic            hit_out
);
    // Flipping the sign bit turns a signed compare into an unsigned one
    function automatic data_word_t order_key(input data_word_t w, input logic sgn);
        order_key = {w[15] ^ sgn, w[14:0]};
    endfunction

    data_word_t key_word;
    data_word_t key_upper;
    data_word_t key_lower;

    always_comb begin
        key_word  = order_key(word_in, signed_in);
        key_upper = order_key(upper_in, signed_in);
        key_lower = order_key(lower_in, signed_in);
        if (key_lower > key_upper) begin // [RQ9]
            hit_out = (key_word > key_upper) && (key_word < key_lower); // [RQ13]
        end else begin
            hit_out = (key_word < key_lower) || (key_word > key_upper); // [RQ13]
        end
    end
endmodule
`default_nettype wire

// >>> adc_result_format.sv
`timescale 1ns/1ns
`default_nettype none
`include "adc_fmt_defines.svh"
module adc_result_format
    import adc_fmt_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        arst_n_in,
    input  wire logic [7:0]  sfr_addr_in,
    input  wire logic [7:0]  sfr_wdata_in,
    input  wire logic        sfr_wr_in,
    input  wire logic        sfr_rd_in,
    output logic      [7:0]  sfr_rdata_out,
    input  wire logic        result_valid_in,
    input  wire logic [11:0] result_code_in,
    input  wire logic        result_diff_in,
    output logic             window_flag_out,
    output logic             justify_left_out
);
    byte_t      result_low_reg;
    byte_t      result_low_next;
    byte_t      result_high_reg;
    byte_t      result_high_next;
    byte_t      upper_high_reg;
    byte_t      upper_high_next;
    byte_t      upper_low_reg;
    byte_t      upper_low_next;
    byte_t      lower_high_reg;
    byte_t      lower_high_next;
    byte_t      lower_low_reg;
    byte_t      lower_low_next;
    byte_t      control_reg;
    byte_t      control_next;
    byte_t      rdata_reg;
    byte_t      rdata_next;
    data_word_t fmt_word;
    logic       window_hit;
    justify_t   justify;

    function automatic logic write_to(input byte_t target);
        write_to = sfr_wr_in && (sfr_addr_in == target);
    endfunction

    // Sign nibble only for differential codes; single-ended stays unsigned
    function automatic data_word_t format_word(input code_t code, input justify_t just,
                                               input logic diff);
        if (just == JUSTIFY_LEFT) begin
            format_word = {code, 4'h0}; // [RQ2] [RQ4]
        end else begin
            format_word = {{4{diff & code[11]}}, code}; // [RQ1] [RQ3] [RQ5] [RQ6]
        end
    endfunction

    assign justify  = justify_t'(control_reg[`CTRL_JUSTIFY_BIT]); // [RQ12]
    assign fmt_word = format_word(result_code_in, justify, result_diff_in);

    adc_window_compare u_compare (
        .word_in   (fmt_word),
        .upper_in  ({upper_high_reg, upper_low_reg}),
        .lower_in  ({lower_high_reg, lower_low_reg}),
        .signed_in (result_diff_in),
        .hit_out   (window_hit)
    );

    always_comb begin
        upper_high_next = upper_high_reg;
        upper_low_next  = upper_low_reg;
        lower_high_next = lower_high_reg;
        lower_low_next  = lower_low_reg;
        if (write_to(`ADDR_UPPER_LIMIT_HIGH)) begin
            upper_high_next = sfr_wdata_in; // [RQ8]
        end
        if (write_to(`ADDR_UPPER_LIMIT_LOW)) begin
            upper_low_next = sfr_wdata_in; // [RQ8]
        end
        if (write_to(`ADDR_LOWER_LIMIT_HIGH)) begin
            lower_high_next = sfr_wdata_in; // [RQ8]
        end
        if (write_to(`ADDR_LOWER_LIMIT_LOW)) begin
            lower_low_next = sfr_wdata_in; // [RQ8]
        end
    end

    // A conversion landing with a software write to the data pair wins
    always_comb begin
        result_low_next  = result_low_reg;
        result_high_next = result_high_reg;
        if (write_to(`ADDR_RESULT_LOW)) begin
            result_low_next = sfr_wdata_in;
        end
        if (write_to(`ADDR_RESULT_HIGH)) begin
            result_high_next = sfr_wdata_in;
        end
        if (result_valid_in) begin
            result_high_next = fmt_word[15:8]; // [RQ1] [RQ2]
            result_low_next  = fmt_word[7:0];  // [RQ3] [RQ4]
        end
    end

    // Set beats a simultaneous clear so no window event is lost
    always_comb begin
        control_next = control_reg;
        if (write_to(`ADDR_CONTROL)) begin
            control_next = sfr_wdata_in; // [RQ11] [RQ12]
        end
        if (result_valid_in && window_hit) begin
            control_next[`CTRL_WINDOW_FLAG_BIT] = 1'b1; // [RQ7]
        end
    end

    always_comb begin
        rdata_next = rdata_reg;
        if (sfr_rd_in) begin
            case (sfr_addr_in)
                `ADDR_RESULT_LOW: begin
                    rdata_next = result_low_reg;
                    if (justify == JUSTIFY_LEFT) begin
                        rdata_next[3:0] = 4'h0; // [RQ4]
                    end
                end
                `ADDR_RESULT_HIGH:      rdata_next = result_high_reg;
                `ADDR_UPPER_LIMIT_HIGH: rdata_next = upper_high_reg;
                `ADDR_UPPER_LIMIT_LOW:  rdata_next = upper_low_reg;
                `ADDR_LOWER_LIMIT_HIGH: rdata_next = lower_high_reg;
                `ADDR_LOWER_LIMIT_LOW:  rdata_next = lower_low_reg;
                `ADDR_CONTROL:          rdata_next = control_reg; // [RQ10]
                default:                rdata_next = `READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            result_low_reg  <= `RESET_RESULT;
            result_high_reg <= `RESET_RESULT;
            upper_high_reg  <= `RESET_UPPER_LIMIT;
            upper_low_reg   <= `RESET_UPPER_LIMIT;
            lower_high_reg  <= `RESET_LOWER_LIMIT;
            lower_low_reg   <= `RESET_LOWER_LIMIT;
            control_reg     <= `RESET_CONTROL;
            rdata_reg       <= `READ_UNMAPPED;
        end else begin
            result_low_reg  <= result_low_next;
            result_high_reg <= result_high_next;
            upper_high_reg  <= upper_high_next;
            upper_low_reg   <= upper_low_next;
            lower_high_reg  <= lower_high_next;
            lower_low_reg   <= lower_low_next;
            control_reg     <= control_next;
            rdata_reg       <= rdata_next;
        end
    end

    assign sfr_rdata_out    = rdata_reg;
    assign window_flag_out  = control_reg[`CTRL_WINDOW_FLAG_BIT]; // [RQ10]
    assign justify_left_out = control_reg[`CTRL_JUSTIFY_BIT];

    sequence s_right_result;
        result_valid_in && (justify == JUSTIFY_RIGHT) && !write_to(`ADDR_CONTROL);
    endsequence

    sequence s_left_low_read;
        sfr_rd_in && (sfr_addr_in == `ADDR_RESULT_LOW) && (justify == JUSTIFY_LEFT);
    endsequence

    sequence s_flag_kept;
        window_flag_out && !(write_to(`ADDR_CONTROL)
                             && !sfr_wdata_in[`CTRL_WINDOW_FLAG_BIT]);
    endsequence

    property p_right_high_data; // [RQ1]
        @(posedge clk_in) disable iff (!arst_n_in)
        s_right_result |=> result_high_reg[3:0] == $past(result_code_in[11:8]);
    endproperty
    a_right_high_data: assert property (p_right_high_data) else $error("high nibble wrong");

    property p_left_high_data; // [RQ2]
        @(posedge clk_in) disable iff (!arst_n_in)
        result_valid_in && (justify == JUSTIFY_LEFT)
            |=> result_high_reg == $past(result_code_in[11:4]);
    endproperty
    a_left_high_data: assert property (p_left_high_data) else $error("left high byte wrong");

    property p_right_low_data; // [RQ3]
        @(posedge clk_in) disable iff (!arst_n_in)
        s_right_result |=> result_low_reg == $past(result_code_in[7:0]);
    endproperty
    a_right_low_data: assert property (p_right_low_data) else $error("right low byte wrong");

    property p_left_low_zero; // [RQ4]
        @(posedge clk_in) disable iff (!arst_n_in)
        s_left_low_read |=> sfr_rdata_out[3:0] == 4'h0;
    endproperty
    a_left_low_zero: assert property (p_left_low_zero) else $error("low nibble not zero");

    property p_single_zero_fill; // [RQ5]
        @(posedge clk_in) disable iff (!arst_n_in)
        s_right_result ##0 !result_diff_in |=> result_high_reg[7:4] == 4'h0;
    endproperty
    a_single_zero_fill: assert property (p_single_zero_fill) else $error("fill not zero");

    property p_diff_sign_ext; // [RQ6]
        @(posedge clk_in) disable iff (!arst_n_in)
        s_right_result ##0 result_diff_in
            |=> result_high_reg[7:4] == {4{result_high_reg[3]}};
    endproperty
    a_diff_sign_ext: assert property (p_diff_sign_ext) else $error("sign extension wrong");

    property p_flag_on_hit; // [RQ7]
        @(posedge clk_in) disable iff (!arst_n_in)
        result_valid_in && window_hit |=> window_flag_out;
    endproperty
    a_flag_on_hit: assert property (p_flag_on_hit) else $error("window flag missed");

    property p_flag_sticky; // [RQ11]
        @(posedge clk_in) disable iff (!arst_n_in)
        s_flag_kept |=> window_flag_out;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("window flag dropped");

    property p_flag_poll; // [RQ10]
        @(posedge clk_in) disable iff (!arst_n_in)
        sfr_rd_in && (sfr_addr_in == `ADDR_CONTROL)
            |=> sfr_rdata_out[`CTRL_WINDOW_FLAG_BIT] == $past(window_flag_out);
    endproperty
    a_flag_poll: assert property (p_flag_poll) else $error("polled flag wrong");

    property p_justify_select; // [RQ12]
        @(posedge clk_in) disable iff (!arst_n_in)
        write_to(`ADDR_CONTROL) |=> justify_left_out == $past(sfr_wdata_in[0]);
    endproperty
    a_justify_select: assert property (p_justify_select) else $error("justify bit wrong");

    property p_limit_byte_write; // [RQ8]
        @(posedge clk_in) disable iff (!arst_n_in)
        write_to(`ADDR_UPPER_LIMIT_LOW) |=> upper_low_reg == $past(sfr_wdata_in)
            && upper_high_reg == $past(upper_high_reg);
    endproperty
    a_limit_byte_write: assert property (p_limit_byte_write) else $error("limit byte wrong");
endmodule
`default_nettype wire

// >>> adc_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module adc_core_model (
    input  wire logic        clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        go_in,
    input  wire logic [11:0] code_cmd_in,
    input  wire logic        diff_cmd_in,
    input  wire logic [3:0]  lag_in,
    output logic             valid_out,
    output logic      [11:0] code_out,
    output logic             diff_out
);
    logic       busy_reg;
    logic [3:0] cnt_reg;
    // Code and mode lines toggle outside the valid cycle so stale values cannot pass
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            busy_reg <= 1'b0;
            cnt_reg <= 4'h0;
            valid_out <= 1'b0;
            code_out <= 12'h5a5;
            diff_out <= 1'b0;
        end else begin
            valid_out <= 1'b0;
            code_out <= ~code_out;
            diff_out <= ~diff_out;
            if (go_in && !busy_reg) begin
                busy_reg <= 1'b1;
                cnt_reg <= lag_in;
            end else if (busy_reg && cnt_reg != 4'h0) begin
                cnt_reg <= cnt_reg - 4'h1;
            end else if (busy_reg) begin
                busy_reg <= 1'b0;
                valid_out <= 1'b1;
                code_out <= code_cmd_in; // Unsigned or two's complement as given
                diff_out <= diff_cmd_in;
            end
        end
    end
endmodule
`default_nettype wire

// >>> adc_result_format_window_detect_tb.sv
`timescale 1ns/1ns
`default_nettype none
module adc_result_format_window_detect_tb;
    import adc_fmt_pkg::*;
    logic       clk_in, arst_n_in, wr, rd, valid, diff, flag, jleft, go, diff_cmd, jl, exp_flag;
    logic [7:0] addr, wdata, rdata;
    code_t      code, code_cmd;
    logic [3:0] lag;
    data_word_t up_w, lo_w;
    int         num_errors, n_compared;
    code_t      codes [6] = '{12'hfff, 12'h800, 12'h7ff, 12'h001, 12'h400, 12'hc00};

    adc_result_format i_adc_result_format (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .sfr_addr_in(addr), .sfr_wdata_in(wdata), .sfr_wr_in(wr), .sfr_rd_in(rd),
        .sfr_rdata_out(rdata), .result_valid_in(valid), .result_code_in(code),
        .result_diff_in(diff), .window_flag_out(flag), .justify_left_out(jleft));
    adc_core_model i_adc_core_model (.clk_in(clk_in), .arst_n_in(arst_n_in), .go_in(go),
        .code_cmd_in(code_cmd), .diff_cmd_in(diff_cmd), .lag_in(lag), .valid_out(valid),
        .code_out(code), .diff_out(diff));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic conclude();
        $display("compares %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input byte_t got, input byte_t exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input byte_t a, input byte_t d);
        @(posedge clk_in);
        #1 wr = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk_in);
        #1 wr = 1'b0;
        if (a == 8'he8) jl = d[0];
        if (a == 8'he8) exp_flag = d[1];
    endtask

    task automatic rd_chk(input byte_t a, input byte_t exp);
        @(posedge clk_in);
        #1 rd = 1'b1;
        addr = a;
        @(posedge clk_in);
        #1 rd = 1'b0;
        @(posedge clk_in);
        #1 chk(rdata, exp);
    endtask

    function automatic logic hit(data_word_t w, logic d);
        logic lt, gt, lg;
        lt = d ? ($signed(w) < $signed(lo_w)) : (w < lo_w);
        gt = d ? ($signed(w) > $signed(up_w)) : (w > up_w);
        // Limits order with the same signedness as the result
        lg = d ? ($signed(lo_w) > $signed(up_w)) : (lo_w > up_w);
        return lg ? (lt && gt) : (lt || gt);
    endfunction

    task automatic conv_chk(input code_t c, input logic d, input logic [3:0] l);
        int         n;
        data_word_t w;
        @(posedge clk_in);
        #1 go = 1'b1;
        code_cmd = c;
        diff_cmd = d;
        lag = l;
        @(posedge clk_in);
        #1 go = 1'b0;
        n = 0;
        while (valid !== 1'b1 && n < 40) begin
            @(posedge clk_in);
            #1 n++;
        end
        if (n >= 40) begin
            num_errors++;
            $display("[ERR] %0t no result from converter", $time);
            conclude();
        end else begin
            @(posedge clk_in);
            #1 w = jl ? {c, 4'h0} : {{4{d & c[11]}}, c};
            exp_flag = exp_flag | hit(w, d);
            chk({7'h0, flag}, {7'h0, exp_flag});
            chk({7'h0, jleft}, {7'h0, jl});
            rd_chk(8'hbf, w[15:8]);
            rd_chk(8'hbe, w[7:0]);
        end
    endtask

    initial begin
        {wr, rd, go, diff_cmd, jl, exp_flag, addr, wdata, code_cmd, lag} = '0;
        {num_errors, n_compared} = '0;
        up_w = 16'hffff;
        lo_w = 16'h0000;
        arst_n_in = 1'b0;
        repeat (12) @(posedge clk_in);
        #1 arst_n_in = 1'b1;
        foreach (codes[k]) rd_chk(k < 2 ? 8'hbe + k[7:0] : 8'hc2 + k[7:0],
                                  k < 2 ? 8'h00 : (k < 4 ? 8'hff : 8'h00));
        rd_chk(8'he8, 8'h00);
        rd_chk(8'h10, 8'h00);
        $display("test reset done");
        for (int j = 0; j < 2; j++) begin
            foreach (codes[k]) begin
                wr_reg(8'he8, {7'h0, j[0]});
                conv_chk(codes[k], k[0], k[3:0]);
            end
        end
        wr_reg(8'hbe, 8'h5a);
        rd_chk(8'hbe, 8'h50);
        $display("test format done");
        wr_reg(8'he8, 8'h00);
        up_w = 16'h0100;
        lo_w = 16'h0300;
        wr_reg(8'hc7, 8'h03);
        wr_reg(8'hc5, 8'h01);
        wr_reg(8'hc4, 8'h00);
        rd_chk(8'hc7, 8'h03);
        rd_chk(8'hc5, 8'h01);
        conv_chk(12'h300, 1'b0, 4'h0);
        conv_chk(12'h100, 1'b0, 4'h2);
        conv_chk(12'h200, 1'b0, 4'h0);
        conv_chk(12'h050, 1'b0, 4'h1);
        rd_chk(8'he8, 8'h02);
        wr_reg(8'he8, 8'h00);
        rd_chk(8'he8, 8'h00);
        up_w = 16'h0300;
        lo_w = 16'h0100;
        wr_reg(8'hc5, 8'h03);
        wr_reg(8'hc7, 8'h01);
        conv_chk(12'h300, 1'b0, 4'h0);
        conv_chk(12'h0ff, 1'b0, 4'h0);
        wr_reg(8'he8, 8'h00);
        conv_chk(12'h301, 1'b0, 4'h3);
        wr_reg(8'he8, 8'h00);
        conv_chk(12'hf00, 1'b1, 4'h0);
        wr_reg(8'h10, 8'h77);
        rd_chk(8'h10, 8'h00);
        $display("test window done");
        wr_reg(8'he8, 8'h01);
        rd_chk(8'hc5, 8'h03);
        @(posedge clk_in);
        #1 arst_n_in = 1'b0;
        repeat (2) @(posedge clk_in);
        #1 arst_n_in = 1'b1;
        jl = 1'b0;
        chk(rdata, 8'h00);
        chk({7'h0, jleft}, 8'h00);
        chk({7'h0, flag}, 8'h00);
        rd_chk(8'hc5, 8'hff);
        rd_chk(8'hc7, 8'h00);
        rd_chk(8'hbf, 8'h00);
        $display("test mid reset done");
        conclude();
    end
endmodule
`default_nettype wire
